// file: verilog/tae_exec_unit.sv
// tagged arithmetic execute stage
// Summary of operation
// - all five operations run in reg-reg, short and long immediate formats.
// - second operand is source2 in reg-reg, else the immediate.
// - arith type class checks both sources in every format.
// - other checks test source1 only, plus source2 in reg-reg format.
// - result carries the data type of source1.
// - reg-reg word: class 110, opcode, src1, src2, type, dest fields.
// - short word: class 111, opcode, src1, dest, type, imm12.
// - opcode 54 adds source1 and the second operand.
// - checked add traps on overflow; coprocessor traps may arise.
// - arith class: fixnums in datapath, floats in opcodes 54 and 55 trap without coprocessor.
// - immediate is type checked only under the arith class check.
// - opcode 52 wraps the sum and never overflow traps.
// - opcode 55 writes second operand minus source1.
// - checked subtract traps on overflow.
// - short immediate is 12-bit signed, long immediate 32-bit signed.
// - opcode 53 wraps second operand minus source1, no overflow trap.
// - multiply never in datapath; traps without coprocessor.
`timescale 1ns/1ns
`include "tae_params.svh"
module tae_exec_unit
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [39:0] instr_word,
    output logic [5:0] src1_addr,
    output logic [5:0] src2_addr,
    input wire logic [37:0] src1_data,
    input wire logic [37:0] src2_data,
    input wire logic cop_present,
    input wire logic cop_can_add,
    input wire logic cop_can_mul,
    output logic rf_wr_en,
    output logic [5:0] rf_wr_addr,
    output logic [37:0] rf_wr_data,
    output logic trap_type,
    output logic trap_ovf,
    output logic trap_cop,
    output logic busy
);
    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic is_fix(input logic [5:0] dt);
        is_fix = (dt == `TAE_DTP_FIXNUM);
    endfunction

    function automatic logic is_flt(input logic [5:0] dt);
        is_flt = (dt == `TAE_DTP_SFLOAT);
    endfunction

    // ------------------------------------------------------------------
    // long format first word is held while the tail arrives
    // ------------------------------------------------------------------
    tae_pkg::tae_state_t state;
    logic [39:0] head;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            state <= tae_pkg::tae_idle;
        else
        begin
            case (state)
                tae_pkg::tae_idle:
                    if (instr_valid && instr_word[`TAE_CLASS_HI:`TAE_CLASS_LO]
                        == `TAE_CLASS_LONG)
                        state <= tae_pkg::tae_wait_tail;
                tae_pkg::tae_wait_tail:
                    if (instr_valid)
                        state <= tae_pkg::tae_idle;
                default:
                    state <= tae_pkg::tae_idle;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            head <= 40'h0;
        else if (state == tae_pkg::tae_idle && instr_valid)
            head <= instr_word;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            busy <= 1'b0;
        else
            busy <= (state == tae_pkg::tae_idle) && instr_valid
                && instr_word[`TAE_CLASS_HI:`TAE_CLASS_LO] == `TAE_CLASS_LONG;
    end

    // ------------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------------
    logic [39:0] w;
    logic fire;
    tae_pkg::tae_fmt_t fmt;
    tae_pkg::tae_op_t op;
    logic [4:0] tchk;
    logic [5:0] dest;
    logic [37:0] imm;

    // the word in flight is the head when a tail is arriving
    assign w = (state == tae_pkg::tae_wait_tail) ? head : instr_word;
    assign tchk = w[`TAE_TYPE_HI:`TAE_TYPE_LO];

    always_comb
    begin
        case (w[`TAE_CLASS_HI:`TAE_CLASS_LO])
            `TAE_CLASS_REG: fmt = tae_pkg::tae_fmt_reg;
            `TAE_CLASS_SHORT: fmt = tae_pkg::tae_fmt_short;
            `TAE_CLASS_LONG: fmt = tae_pkg::tae_fmt_long;
            default: fmt = tae_pkg::tae_fmt_bad;
        endcase
        case (w[`TAE_OPC_HI:`TAE_OPC_LO])
            `TAE_OPC_ADD: op = tae_pkg::tae_op_add;
            `TAE_OPC_ADDW: op = tae_pkg::tae_op_addw;
            `TAE_OPC_SUB: op = tae_pkg::tae_op_sub;
            `TAE_OPC_SUBW: op = tae_pkg::tae_op_subw;
            `TAE_OPC_MUL: op = tae_pkg::tae_op_mul;
            default: op = tae_pkg::tae_op_none;
        endcase
    end

    // register fields are read in the same cycle as the instruction
    assign src1_addr = w[`TAE_SRC1_HI:`TAE_SRC1_LO];
    assign src2_addr = w[`TAE_F22_HI:`TAE_F22_LO];
    assign dest = (fmt == tae_pkg::tae_fmt_short) ?
        w[`TAE_F22_HI:`TAE_F22_LO] : w[`TAE_DEST_HI:0];

    always_comb
    begin
        if (fmt == tae_pkg::tae_fmt_short)
            imm = {`TAE_DTP_FIXNUM, {20{w[`TAE_IMM12_HI]}},
                w[`TAE_IMM12_HI:0]};
        else
            imm = {instr_word[`TAE_TAIL_TAG_HI:`TAE_TAIL_TAG_LO],
                3'h0, instr_word[31:0]};
    end

    // fire when a whole instruction is present and it is ours
    assign fire = instr_valid && op != tae_pkg::tae_op_none
        && (fmt == tae_pkg::tae_fmt_reg || fmt == tae_pkg::tae_fmt_short
        || (fmt == tae_pkg::tae_fmt_long
        && state == tae_pkg::tae_wait_tail));

    // ------------------------------------------------------------------
    // operands, type checks and arithmetic
    // ------------------------------------------------------------------
    logic [37:0] opb;
    logic [5:0] dt1, dt2;
    logic chk2, bad1, bad2, arith, flt_any;
    logic [32:0] sum, dif;
    logic ovf_add, ovf_sub;

    assign opb = (fmt == tae_pkg::tae_fmt_reg) ? src2_data : imm;
    assign dt1 = src1_data[37:32];
    assign dt2 = opb[37:32];
    assign arith = (tchk == `TAE_TCHK_ARITH);
    // immediate joins the check only under the arith class
    assign chk2 = arith || fmt == tae_pkg::tae_fmt_reg;
    // floats matter only under the arith class; otherwise plain bits
    assign flt_any = arith && (is_flt(dt1) || is_flt(dt2));

    always_comb
    begin
        bad1 = 1'b0;
        bad2 = 1'b0;
        case (tchk)
            `TAE_TCHK_FIXNUM:
            begin
                bad1 = !is_fix(dt1);
                bad2 = !is_fix(dt2);
            end
            `TAE_TCHK_ARITH:
            begin
                bad1 = !is_fix(dt1) && !is_flt(dt1);
                bad2 = !is_fix(dt2) && !is_flt(dt2);
            end
            default:
            begin
                bad1 = 1'b0;
                bad2 = 1'b0;
            end
        endcase
    end

    assign sum = {src1_data[31], src1_data[31:0]}
        + {opb[31], opb[31:0]};
    assign dif = {opb[31], opb[31:0]}
        - {src1_data[31], src1_data[31:0]};
    assign ovf_add = sum[32] ^ sum[31];
    assign ovf_sub = dif[32] ^ dif[31];

    logic next_type, next_ovf, next_cop, next_wr;
    logic [31:0] next_val;
    logic cop_op;

    // only checked add and subtract hand floats to the coprocessor
    assign cop_op = flt_any
        && (op == tae_pkg::tae_op_add || op == tae_pkg::tae_op_sub);

    always_comb
    begin
        next_type = bad1 || (chk2 && bad2);
        next_ovf = 1'b0;
        next_cop = 1'b0;
        next_val = sum[31:0];
        case (op)
            tae_pkg::tae_op_add:
            begin
                next_cop = cop_op && !(cop_present && cop_can_add);
                next_ovf = ovf_add && !flt_any;
            end
            tae_pkg::tae_op_sub:
            begin
                next_val = dif[31:0];
                next_cop = cop_op && !(cop_present && cop_can_add);
                next_ovf = ovf_sub && !flt_any;
            end
            tae_pkg::tae_op_subw: next_val = dif[31:0];
            // no product is formed here; the coprocessor owns multiply
            tae_pkg::tae_op_mul: next_cop = !(cop_present && cop_can_mul);
            default: next_val = sum[31:0];
        endcase
        if (next_type)
        begin
            next_ovf = 1'b0;
            next_cop = 1'b0;
        end
        // floats handled by a present coprocessor are not written here
        next_wr = !(next_type || next_ovf || next_cop || cop_op
            || op == tae_pkg::tae_op_mul);
    end

    tae_result_reg u_res
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .load(fire),
        .next_wr_en(next_wr),
        .next_dest(dest),
        .next_data({dt1, next_val}),
        .next_trap_type(next_type),
        .next_trap_ovf(next_ovf),
        .next_trap_cop(next_cop),
        .wr_en(rf_wr_en),
        .dest(rf_wr_addr),
        .data(rf_wr_data),
        .trap_type(trap_type),
        .trap_ovf(trap_ovf),
        .trap_cop(trap_cop)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_no_wr_on_trap;
        @(posedge ref_clk) disable iff (rst)
        (trap_type || trap_ovf || trap_cop) |-> !rf_wr_en;
    endproperty
    a_no_wr_on_trap: assert property (p_no_wr_on_trap)
        else $error("write during trap");

    property p_type_of_src1;
        @(posedge ref_clk) disable iff (rst)
        fire && next_wr |=> rf_wr_data[37:32] == $past(src1_data[37:32]);
    endproperty
    a_type_of_src1: assert property (p_type_of_src1)
        else $error("result type not source1");

    property p_wrap_add;
        @(posedge ref_clk) disable iff (rst)
        fire && op == tae_pkg::tae_op_addw |=> !trap_ovf;
    endproperty
    a_wrap_add: assert property (p_wrap_add)
        else $error("wrapping add trapped");

    property p_wrap_sub;
        @(posedge ref_clk) disable iff (rst)
        fire && op == tae_pkg::tae_op_subw && !next_type |=> rf_wr_en
            && rf_wr_data[31:0] == $past(opb[31:0] - src1_data[31:0]);
    endproperty
    a_wrap_sub: assert property (p_wrap_sub)
        else $error("wrapping subtract wrong");

    property p_add_ovf;
        @(posedge ref_clk) disable iff (rst)
        fire && op == tae_pkg::tae_op_add && !next_type && !flt_any
            && ovf_add |=> trap_ovf && !rf_wr_en;
    endproperty
    a_add_ovf: assert property (p_add_ovf)
        else $error("add overflow missed");

    property p_sub_ovf;
        @(posedge ref_clk) disable iff (rst)
        fire && op == tae_pkg::tae_op_sub && !next_type && !flt_any
            && ovf_sub |=> trap_ovf;
    endproperty
    a_sub_ovf: assert property (p_sub_ovf)
        else $error("subtract overflow missed");

    property p_mul_no_wr;
        @(posedge ref_clk) disable iff (rst)
        fire && op == tae_pkg::tae_op_mul |=> !rf_wr_en;
    endproperty
    a_mul_no_wr: assert property (p_mul_no_wr)
        else $error("multiply written by datapath");

    property p_imm_unchecked;
        @(posedge ref_clk) disable iff (rst)
        fire && fmt != tae_pkg::tae_fmt_reg && !arith && !bad1
            |=> !trap_type;
    endproperty
    a_imm_unchecked: assert property (p_imm_unchecked)
        else $error("immediate was type checked");

    property p_long_two_words;
        @(posedge ref_clk) disable iff (rst)
        state == tae_pkg::tae_idle && instr_valid
            && fmt == tae_pkg::tae_fmt_long |=> !rf_wr_en && !trap_type;
    endproperty
    a_long_two_words: assert property (p_long_two_words)
        else $error("long format acted on one word");

    c_reg: cover property (@(posedge ref_clk)
        fire && fmt == tae_pkg::tae_fmt_reg ##1 rf_wr_en);
    c_short: cover property (@(posedge ref_clk)
        fire && fmt == tae_pkg::tae_fmt_short ##1 rf_wr_en);
    c_long: cover property (@(posedge ref_clk)
        fire && fmt == tae_pkg::tae_fmt_long ##1 rf_wr_en);
    c_ovf: cover property (@(posedge ref_clk) trap_ovf);
endmodule

// file: include/tae_params.svh
// constants for the tagged arithmetic execute stage
`ifndef TAE_PARAMS_SVH
`define TAE_PARAMS_SVH

// ----------------------------------------------------------------------
// instruction word fields
// ----------------------------------------------------------------------
`define TAE_CLASS_HI 37
`define TAE_CLASS_LO 35
`define TAE_OPC_HI 34
`define TAE_OPC_LO 29
`define TAE_SRC1_HI 28
`define TAE_SRC1_LO 23
`define TAE_F22_HI 22
`define TAE_F22_LO 17
`define TAE_TYPE_HI 16
`define TAE_TYPE_LO 12
`define TAE_IMM12_HI 11
`define TAE_DEST_HI 5
`define TAE_TAIL_TAG_HI 39
`define TAE_TAIL_TAG_LO 37

// ----------------------------------------------------------------------
// class codes and opcodes (octal)
// ----------------------------------------------------------------------
`define TAE_CLASS_REG 3'o6
`define TAE_CLASS_SHORT 3'o7
`define TAE_CLASS_LONG 3'o5
`define TAE_OPC_ADD 6'o54
`define TAE_OPC_ADDW 6'o52
`define TAE_OPC_SUB 6'o55
`define TAE_OPC_SUBW 6'o53
`define TAE_OPC_MUL 6'o56

// ----------------------------------------------------------------------
// type check codes and data types
// ----------------------------------------------------------------------
`define TAE_TCHK_NONE 5'h00
`define TAE_TCHK_FIXNUM 5'h01
`define TAE_TCHK_ARITH 5'h02
`define TAE_DTP_FIXNUM 6'h08
`define TAE_DTP_SFLOAT 6'h09

`endif

// file: include/tae_pkg.sv
// types for the tagged arithmetic execute stage
package tae_pkg;
    typedef enum logic [1:0] {tae_fmt_reg, tae_fmt_short, tae_fmt_long,
        tae_fmt_bad} tae_fmt_t;
    typedef enum logic [1:0] {tae_idle, tae_wait_tail} tae_state_t;
    typedef enum logic [2:0] {tae_op_add, tae_op_addw, tae_op_sub,
        tae_op_subw, tae_op_mul, tae_op_none} tae_op_t;
endpackage

// file: verilog/tae_result_reg.sv
// registered result and trap outputs of the execute stage
`timescale 1ns/1ns
module tae_result_reg
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic load,
    input wire logic next_wr_en,
    input wire logic [5:0] next_dest,
    input wire logic [37:0] next_data,
    input wire logic next_trap_type,
    input wire logic next_trap_ovf,
    input wire logic next_trap_cop,
    output logic wr_en,
    output logic [5:0] dest,
    output logic [37:0] data,
    output logic trap_type,
    output logic trap_ovf,
    output logic trap_cop
);
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wr_en <= 1'b0;
            trap_type <= 1'b0;
            trap_ovf <= 1'b0;
            trap_cop <= 1'b0;
        end
        else
        begin
            wr_en <= load & next_wr_en;
            trap_type <= load & next_trap_type;
            trap_ovf <= load & next_trap_ovf;
            trap_cop <= load & next_trap_cop;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            dest <= 6'h00;
            data <= 38'h0;
        end
        else if (load)
        begin
            dest <= next_dest;
            data <= next_data;
        end
    end
endmodule

// file: verification/tae_rf_model.sv
// register file model answering the execute stage's read and write ports
`timescale 1ns/1ns
module tae_rf_model
(
    input wire logic ref_clk,
    input wire logic [5:0] src1_addr,
    input wire logic [5:0] src2_addr,
    output logic [37:0] src1_data,
    output logic [37:0] src2_data,
    input wire logic rf_wr_en,
    input wire logic [5:0] rf_wr_addr,
    input wire logic [37:0] rf_wr_data
);
    logic [37:0] regs [64];

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    // reads are combinational, same cycle as the address
    assign src1_data = regs[src1_addr];
    assign src2_data = regs[src2_addr];

    initial
    begin
        for (int i = 0; i < 64; i++)
            regs[i] = 38'h0;
    end

    always @(posedge ref_clk)
    begin
        if (rf_wr_en === 1'b1)
            regs[rf_wr_addr] <= rf_wr_data;
    end
endmodule

// file: verification/tb_top.sv
// self-checking bench for the tagged arithmetic execute stage
`timescale 1ns/1ns
`include "tae_params.svh"
module tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic instr_valid = 1'b0;
    logic [39:0] instr_word = 40'h0;
    logic cop_present = 1'b0;
    logic cop_can_add = 1'b0;
    logic cop_can_mul = 1'b0;
    logic [5:0] src1_addr;
    logic [5:0] src2_addr;
    logic [37:0] src1_data;
    logic [37:0] src2_data;
    logic rf_wr_en;
    logic [5:0] rf_wr_addr;
    logic [37:0] rf_wr_data;
    logic trap_type;
    logic trap_ovf;
    logic trap_cop;
    logic busy;
    int fail_count = 0;
    int checks_done = 0;
    logic [5:0] opcs [5];
    logic [31:0] op2 [3];
    logic [39:0] w;
    logic [31:0] v;
    logic [5:0] d;

    always #5 ref_clk = ~ref_clk;

    tae_exec_unit DUT (.ref_clk(ref_clk), .rst(rst),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .src1_addr(src1_addr), .src2_addr(src2_addr),
        .src1_data(src1_data), .src2_data(src2_data),
        .cop_present(cop_present), .cop_can_add(cop_can_add),
        .cop_can_mul(cop_can_mul), .rf_wr_en(rf_wr_en),
        .rf_wr_addr(rf_wr_addr), .rf_wr_data(rf_wr_data),
        .trap_type(trap_type), .trap_ovf(trap_ovf),
        .trap_cop(trap_cop), .busy(busy));

    tae_rf_model u_rf (.ref_clk(ref_clk), .src1_addr(src1_addr),
        .src2_addr(src2_addr), .src1_data(src1_data),
        .src2_data(src2_data), .rf_wr_en(rf_wr_en),
        .rf_wr_addr(rf_wr_addr), .rf_wr_data(rf_wr_data));

    // ------------------------------------------------------------------
    // word builders and access tasks
    // ------------------------------------------------------------------
    function automatic logic [39:0] reg_word(input logic [5:0] o, s1, s2,
        input logic [4:0] tc, input logic [5:0] dst);
        return {2'h0, `TAE_CLASS_REG, o, s1, s2, tc, 6'h00, dst};
    endfunction

    function automatic logic [39:0] short_word(input logic [5:0] o, s1, dst,
        input logic [4:0] tc, input logic [11:0] im);
        return {2'h0, `TAE_CLASS_SHORT, o, s1, dst, tc, im};
    endfunction

    function automatic logic [39:0] long_word(input logic [5:0] o, s1,
        input logic [4:0] tc, input logic [5:0] dst);
        return {2'h0, `TAE_CLASS_LONG, o, s1, 6'h00, tc, 6'h00, dst};
    endfunction

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic result(input logic [3:0] ef, input logic [5:0] ea,
        input logic [37:0] ed);
        check({rf_wr_en, trap_type, trap_ovf, trap_cop,
            rf_wr_en === 1'b1 ? {rf_wr_addr, rf_wr_data} : 44'h0},
            {ef, ef[3] ? {ea, ed} : 44'h0});
    endtask

    // leaves instr_valid high so calls run back to back
    task automatic op(input logic [39:0] hw, input logic [39:0] tw,
        input logic lng, input logic [3:0] ef, input logic [5:0] ea,
        input logic [37:0] ed);
        instr_valid = 1'b1;
        instr_word = hw;
        if (lng)
        begin
            @(posedge ref_clk);
            #1;
            check({busy, rf_wr_en, trap_type, trap_ovf, trap_cop},
                5'h10);
            instr_word = tw;
        end
        @(posedge ref_clk);
        #1;
        result(ef, ea, ed);
    endtask

    task automatic idle;
        instr_valid = 1'b0;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic end_of_test;
        if (fail_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #200000;
        fail_count++;
        end_of_test();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        opcs = '{`TAE_OPC_ADD, `TAE_OPC_ADDW, `TAE_OPC_SUB, `TAE_OPC_SUBW,
            `TAE_OPC_MUL};
        op2 = '{32'h7, 32'hFFFFFFF6, 32'h1000};
        #3;
        u_rf.regs[1] = {`TAE_DTP_FIXNUM, 32'h64};
        u_rf.regs[2] = {`TAE_DTP_FIXNUM, 32'h7};
        u_rf.regs[3] = {`TAE_DTP_FIXNUM, 32'h7FFFFFFF};
        u_rf.regs[4] = {`TAE_DTP_SFLOAT, 32'h3F800000};
        u_rf.regs[5] = {`TAE_DTP_FIXNUM, 32'h80000000};
        u_rf.regs[6] = {6'h20, 32'h5};
        u_rf.regs[21] = {`TAE_DTP_FIXNUM, 32'h55};
        repeat (12) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        check({rf_wr_en, trap_type, trap_ovf, trap_cop, busy},
            5'h00);
        // every operation in every format, mul traps with no coprocessor
        for (int f = 0; f < 3; f++)
        begin
            for (int i = 0; i < 5; i++)
            begin
                d = 6'h0A + 6'(i);
                if (f == 0)
                    w = reg_word(opcs[i], 6'h01, 6'h02, `TAE_TCHK_NONE, d);
                else if (f == 1)
                    w = short_word(opcs[i], 6'h01, d, `TAE_TCHK_NONE,
                        12'hFF6);
                else
                    w = long_word(opcs[i], 6'h01, `TAE_TCHK_NONE, d);
                v = i < 2 ? 32'h64 + op2[f] : op2[f] - 32'h64;
                op(w, {3'h1, 5'h00, 32'h1000}, f == 2, i == 4 ? 4'h1 : 4'h8,
                    d, {`TAE_DTP_FIXNUM, v});
            end
        end
        // untyped source with no check, then overflow traps and wraps of add and subtract
        op(reg_word(`TAE_OPC_ADD, 6'h06, 6'h01, `TAE_TCHK_NONE, 6'h14), 40'h0,
            1'b0, 4'h8, 6'h14, {6'h20, 32'h69});
        op(reg_word(`TAE_OPC_ADD, 6'h03, 6'h02, `TAE_TCHK_NONE, 6'h15), 40'h0,
            1'b0, 4'h2, 6'h15, 38'h0);
        op(reg_word(`TAE_OPC_ADDW, 6'h03, 6'h02, `TAE_TCHK_NONE, 6'h16),
            40'h0, 1'b0, 4'h8, 6'h16,
            {`TAE_DTP_FIXNUM, 32'h80000006});
        op(reg_word(`TAE_OPC_SUB, 6'h02, 6'h05, `TAE_TCHK_NONE, 6'h15), 40'h0,
            1'b0, 4'h2, 6'h15, 38'h0);
        op(reg_word(`TAE_OPC_SUBW, 6'h02, 6'h05, `TAE_TCHK_NONE, 6'h17),
            40'h0, 1'b0, 4'h8, 6'h17,
            {`TAE_DTP_FIXNUM, 32'h7FFFFFF9});
        // wrapping add on a float source with no check is plain bits
        op(reg_word(`TAE_OPC_ADDW, 6'h04, 6'h01, `TAE_TCHK_NONE, 6'h1F),
            40'h0, 1'b0, 4'h8, 6'h1F,
            {`TAE_DTP_SFLOAT, 32'h3F800064});
        idle();
        check(u_rf.regs[21], {`TAE_DTP_FIXNUM, 32'h55});
        // type checks: fixnum check vs arith class check
        op(reg_word(`TAE_OPC_ADD, 6'h01, 6'h06, `TAE_TCHK_FIXNUM, 6'h18),
            40'h0, 1'b0, 4'h4, 6'h18, 38'h0);
        op(short_word(`TAE_OPC_ADD, 6'h06, 6'h18, `TAE_TCHK_FIXNUM, 12'h001),
            40'h0, 1'b0, 4'h4, 6'h18, 38'h0);
        op(long_word(`TAE_OPC_ADD, 6'h01, `TAE_TCHK_FIXNUM, 6'h19),
            {3'h7, 5'h00, 32'h10}, 1'b1, 4'h8, 6'h19,
            {`TAE_DTP_FIXNUM, 32'h74});
        op(long_word(`TAE_OPC_ADD, 6'h01, `TAE_TCHK_ARITH, 6'h19),
            {3'h7, 5'h00, 32'h10}, 1'b1, 4'h4, 6'h19, 38'h0);
        op(long_word(`TAE_OPC_SUB, 6'h01, `TAE_TCHK_ARITH, 6'h1A),
            {3'h1, 5'h00, 32'h10}, 1'b1, 4'h8, 6'h1A,
            {`TAE_DTP_FIXNUM, 32'hFFFFFFAC});
        op(short_word(`TAE_OPC_ADD, 6'h06, 6'h1A, `TAE_TCHK_ARITH, 12'h001),
            40'h0, 1'b0, 4'h4, 6'h1A, 38'h0);
        // float operands and multiply against coprocessor capability
        w = reg_word(`TAE_OPC_ADD, 6'h04, 6'h01, `TAE_TCHK_ARITH, 6'h1B);
        op(w, 40'h0, 1'b0, 4'h1, 6'h1B, 38'h0);
        cop_present = 1'b1;
        cop_can_add = 1'b1;
        op(w, 40'h0, 1'b0, 4'h0, 6'h1B, 38'h0);
        w = reg_word(`TAE_OPC_MUL, 6'h01, 6'h02, `TAE_TCHK_ARITH, 6'h1B);
        op(w, 40'h0, 1'b0, 4'h1, 6'h1B, 38'h0);
        cop_can_mul = 1'b1;
        op(w, 40'h0, 1'b0, 4'h0, 6'h1B, 38'h0);
        // subtracting an immediate is an add of its negation
        op(short_word(`TAE_OPC_ADD, 6'h01, 6'h1C, `TAE_TCHK_ARITH, 12'hB2E),
            40'h0, 1'b0, 4'h8, 6'h1C,
            {`TAE_DTP_FIXNUM, 32'hFFFFFB92});
        op(short_word(`TAE_OPC_ADD, 6'h01, 6'h1C, `TAE_TCHK_NONE, 12'h7FF),
            40'h0, 1'b0, 4'h8, 6'h1C,
            {`TAE_DTP_FIXNUM, 32'h863});
        op(short_word(`TAE_OPC_ADD, 6'h01, 6'h1C, `TAE_TCHK_NONE, 12'h800),
            40'h0, 1'b0, 4'h8, 6'h1C,
            {`TAE_DTP_FIXNUM, 32'hFFFFF864});
        // opcodes and classes outside this stage give no answer
        op(reg_word(6'o42, 6'h01, 6'h02, `TAE_TCHK_NONE, 6'h1D), 40'h0, 1'b0,
            4'h0, 6'h1D, 38'h0);
        op({2'h0, 3'h0, `TAE_OPC_ADD, 35'h0}, 40'h0, 1'b0, 4'h0, 6'h00,
            38'h0);
        // long format with an idle gap before the tail word
        instr_word = long_word(`TAE_OPC_ADD, 6'h02, `TAE_TCHK_NONE, 6'h1E);
        @(posedge ref_clk);
        #1;
        check({busy, rf_wr_en}, 2'h2);
        instr_valid = 1'b0;
        @(posedge ref_clk);
        #1;
        check({rf_wr_en, trap_type, trap_ovf, trap_cop}, 4'h0);
        op({3'h1, 5'h00, 32'hFFFFFF00}, 40'h0, 1'b0, 4'h8, 6'h1E,
            {`TAE_DTP_FIXNUM, 32'hFFFFFF07});
        idle();
        end_of_test();
    end
endmodule
